// File: shared/dispatch_pkg.sv
// Contract
// - any library entry first drains the pipeline, saves the PC, then dispatches.
// - routine address is an entry offset added to a programmable base register.
// - instruction address mapping is off while the library mode is active.
// - interrupts are held disabled while the library mode is active.
// - mode-only instructions outside the library mode raise the illegal-opcode trap.
// - privileged return jumps to the saved address; its bit 0 selects the mode.
// - return with bit 0 clear loads PC, re-enables interrupts and mapping.
// - reset enters the library mode at the reset entry until a clearing return.
// - hardware errors dispatch to an error routine chosen by the error type.
// - a serious system error dispatches to the machine-check entry.
// - a sensed interrupt dispatches to the interrupt routine for acknowledgment.
// - data or instruction translation misses dispatch to the matching fill routine.
// - call function field selects routine; unsupported codes take the illegal-opcode trap.
// - privileged call outside kernel mode goes to illegal-opcode entry 13E0.
// - every dispatched call runs its routine in the library mode.
// - new PC takes offset bits 13:0 and base bits 33:14; base resets zero.
// - priority reset, machine check, arithmetic, interrupt at 0000, 0020, 0060, 00E0.
// - kernel mode is both current mode bits zero; else privileged ops trap.
package dispatch_pkg;
  // ==========================================================
  // widths
  localparam int PC_W = 34;
  localparam int OFS_W = 14;
  localparam int BASE_W = 20;
  localparam logic [PC_W-1:0] PC_STEP = 34'h0_0000_0004;
  // ==========================================================
  // entry offsets
  localparam logic [OFS_W-1:0] OFS_RESET = 14'h0000;
  localparam logic [OFS_W-1:0] OFS_MACHINE_CHECK_ENTRY = 14'h0020;
  localparam logic [OFS_W-1:0] OFS_ARITHMETIC_TRAP_ENTRY = 14'h0060;
  localparam logic [OFS_W-1:0] OFS_INTR = 14'h00E0;
  localparam logic [OFS_W-1:0] OFS_DERR0 = 14'h01E0;
  localparam logic [OFS_W-1:0] OFS_DERR1 = 14'h08E0;
  localparam logic [OFS_W-1:0] OFS_DERR2 = 14'h09E0;
  localparam logic [OFS_W-1:0] OFS_DERR3 = 14'h11E0;
  localparam logic [OFS_W-1:0] OFS_ITB = 14'h03E0;
  localparam logic [OFS_W-1:0] OFS_DTB = 14'h05E0;
  localparam logic [OFS_W-1:0] OFS_ILLEGAL = 14'h13E0;
  localparam logic [OFS_W-1:0] OFS_CALL = 14'h2000;
  localparam int CALL_SHIFT = 6;
  // ==========================================================
  // call function field and mode bits
  localparam int CALL_PRIV_BIT = 7;
  localparam int CALL_BAD_BIT = 6;
  localparam logic [1:0] KERNEL_MODE = 2'h0;
  localparam int STAY_BIT = 0;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_BASE = 8'h00;
  localparam logic [7:0] REG_ERA_LO = 8'h04;
  localparam logic [7:0] REG_ERA_HI = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [BASE_W-1:0] BASE_RESET = 20'h0_0000;
  // ==========================================================
  // sequencer and causes
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DRAIN = 4'b0010,
    ST_DISPATCH = 4'b0100,
    ST_RETURN = 4'b1000
  } state_t;
  typedef enum logic [3:0] {
    C_NONE, C_RESET, C_MACHINE_CHECK_ENTRY, C_ARITHMETIC_TRAP_ENTRY, C_INTR, C_DERR, C_ITB, C_DTB, C_ILLEGAL, C_CALL
  } cause_t;
endpackage : dispatch_pkg

// File: rtl/privileged_mode_dispatch.sv
`timescale 1ns/1ps
module privileged_mode_dispatch (
  // clock, reset, enable
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // hardware event pulses
  input wire logic EVT_MACHINE_CHECK_ENTRY_I,
  input wire logic EVT_ARITHMETIC_TRAP_ENTRY_I,
  input wire logic EVT_INTR_I,
  input wire logic EVT_DERR_I,
  input wire logic [1:0] DERR_TYPE_I,
  input wire logic EVT_ITB_MISS_I,
  input wire logic EVT_DTB_MISS_I,
  // instruction issue
  input wire logic ISSUE_CALL_I,
  input wire logic [7:0] CALL_FUNC_I,
  input wire logic ISSUE_MODE_ONLY_I,
  input wire logic ISSUE_RETURN_I,
  input wire logic [33:0] ISSUE_PC_I,
  input wire logic [1:0] CUR_MODE_I,
  input wire logic [33:0] CUR_PC_I,
  // pipeline control
  output logic DRAIN_REQ_O,
  input wire logic DRAIN_DONE_I,
  output logic PC_LOAD_O,
  output logic [33:0] NEW_PC_O,
  output logic LIB_MODE_O,
  output logic INT_ENABLE_O,
  output logic IMAP_ENABLE_O
);
  // ==========================================================
  // state
  dispatch_pkg::state_t state;
  dispatch_pkg::cause_t sel_cause;
  dispatch_pkg::cause_t next_cause;
  logic [dispatch_pkg::OFS_W-1:0] next_ofs;
  logic [dispatch_pkg::OFS_W-1:0] sel_ofs;
  logic [dispatch_pkg::BASE_W-1:0] base;
  logic [dispatch_pkg::PC_W-1:0] era;
  logic [dispatch_pkg::PC_W-1:0] call_ret;
  logic [dispatch_pkg::PC_W-1:0] illegal_pc;
  logic [6:0] call_idx;
  logic [1:0] derr_type;
  logic mode;
  logic pend_reset, pend_machine_check_entry, pend_arithmetic_trap_entry, pend_intr, pend_derr, pend_itb, pend_dtb;
  logic pend_ill, pend_call;
  logic call_bad, call_priv_fault, set_ill, wb_req, wb_wr, take;
  logic [31:0] wmask;

  // ==========================================================
  // instruction checks
  always_comb begin
    call_bad = CALL_FUNC_I[dispatch_pkg::CALL_BAD_BIT];
    call_priv_fault = !CALL_FUNC_I[dispatch_pkg::CALL_PRIV_BIT]
                      && (CUR_MODE_I != dispatch_pkg::KERNEL_MODE);
    // mode-only instructions and a return outside the mode
    set_ill = (!mode && (ISSUE_MODE_ONLY_I || ISSUE_RETURN_I))
              || (ISSUE_CALL_I && (call_bad || call_priv_fault));
  end

  // ==========================================================
  // cause selection, highest first
  always_comb begin
    next_cause = dispatch_pkg::C_NONE;
    next_ofs = dispatch_pkg::OFS_RESET;
    if (pend_reset) begin
      next_cause = dispatch_pkg::C_RESET;
      next_ofs = dispatch_pkg::OFS_RESET;
    end else if (pend_machine_check_entry) begin
      next_cause = dispatch_pkg::C_MACHINE_CHECK_ENTRY;
      next_ofs = dispatch_pkg::OFS_MACHINE_CHECK_ENTRY;
    end else if (pend_arithmetic_trap_entry) begin
      next_cause = dispatch_pkg::C_ARITHMETIC_TRAP_ENTRY;
      next_ofs = dispatch_pkg::OFS_ARITHMETIC_TRAP_ENTRY;
    end else if (pend_intr) begin
      next_cause = dispatch_pkg::C_INTR;
      next_ofs = dispatch_pkg::OFS_INTR;
    end else if (pend_derr) begin
      next_cause = dispatch_pkg::C_DERR;
      case (derr_type)
        2'h0: next_ofs = dispatch_pkg::OFS_DERR0;
        2'h1: next_ofs = dispatch_pkg::OFS_DERR1;
        2'h2: next_ofs = dispatch_pkg::OFS_DERR2;
        default: next_ofs = dispatch_pkg::OFS_DERR3;
      endcase
    end else if (pend_itb) begin
      next_cause = dispatch_pkg::C_ITB;
      next_ofs = dispatch_pkg::OFS_ITB;
    end else if (pend_dtb) begin
      next_cause = dispatch_pkg::C_DTB;
      next_ofs = dispatch_pkg::OFS_DTB;
    end else if (pend_ill) begin
      next_cause = dispatch_pkg::C_ILLEGAL;
      next_ofs = dispatch_pkg::OFS_ILLEGAL;
    end else if (pend_call) begin
      next_cause = dispatch_pkg::C_CALL;
      next_ofs = dispatch_pkg::OFS_CALL
                 | {1'b0, call_idx, {dispatch_pkg::CALL_SHIFT{1'b0}}};
    end
  end

  // lower causes wait while in the mode; reset is taken regardless
  assign take = (state == dispatch_pkg::ST_IDLE) && (next_cause != dispatch_pkg::C_NONE)
                && (!mode || pend_reset);

  // ==========================================================
  // pending causes: a new event wins over the clear of its dispatch
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      pend_reset <= 1'b1;
      {pend_machine_check_entry, pend_arithmetic_trap_entry, pend_intr, pend_derr} <= 4'h0;
      {pend_itb, pend_dtb, pend_ill, pend_call} <= 4'h0;
      derr_type <= 2'h0;
      call_idx <= 7'h00;
      call_ret <= '0;
      illegal_pc <= '0;
    end else if (CE_I) begin
      if (take) begin
        case (next_cause)
          dispatch_pkg::C_RESET: pend_reset <= 1'b0;
          dispatch_pkg::C_MACHINE_CHECK_ENTRY: pend_machine_check_entry <= 1'b0;
          dispatch_pkg::C_ARITHMETIC_TRAP_ENTRY: pend_arithmetic_trap_entry <= 1'b0;
          dispatch_pkg::C_INTR: pend_intr <= 1'b0;
          dispatch_pkg::C_DERR: pend_derr <= 1'b0;
          dispatch_pkg::C_ITB: pend_itb <= 1'b0;
          dispatch_pkg::C_DTB: pend_dtb <= 1'b0;
          dispatch_pkg::C_ILLEGAL: pend_ill <= 1'b0;
          dispatch_pkg::C_CALL: pend_call <= 1'b0;
          default: pend_reset <= pend_reset;
        endcase
      end
      if (EVT_MACHINE_CHECK_ENTRY_I) pend_machine_check_entry <= 1'b1;
      if (EVT_ARITHMETIC_TRAP_ENTRY_I) pend_arithmetic_trap_entry <= 1'b1;
      if (EVT_INTR_I) pend_intr <= 1'b1;
      if (EVT_DERR_I) begin
        pend_derr <= 1'b1;
        derr_type <= DERR_TYPE_I;
      end
      if (EVT_ITB_MISS_I) pend_itb <= 1'b1;
      if (EVT_DTB_MISS_I) pend_dtb <= 1'b1;
      if (set_ill) begin
        pend_ill <= 1'b1;
        illegal_pc <= ISSUE_PC_I;
      end else if (ISSUE_CALL_I) begin
        pend_call <= 1'b1;
        call_idx <= {CALL_FUNC_I[dispatch_pkg::CALL_PRIV_BIT], CALL_FUNC_I[5:0]};
        call_ret <= ISSUE_PC_I + dispatch_pkg::PC_STEP;
      end
    end
  end

  // ==========================================================
  // sequencer: drain, save, dispatch
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      state <= dispatch_pkg::ST_IDLE;
      sel_cause <= dispatch_pkg::C_NONE;
      sel_ofs <= dispatch_pkg::OFS_RESET;
      DRAIN_REQ_O <= 1'b0;
    end else if (CE_I) begin
      case (state)
        dispatch_pkg::ST_IDLE: begin
          if (take) begin
            sel_cause <= next_cause;
            sel_ofs <= next_ofs;
            DRAIN_REQ_O <= 1'b1;
            state <= dispatch_pkg::ST_DRAIN;
          end else if (ISSUE_RETURN_I && mode) begin
            state <= dispatch_pkg::ST_RETURN;
          end
        end
        dispatch_pkg::ST_DRAIN: begin
          if (DRAIN_DONE_I) begin
            DRAIN_REQ_O <= 1'b0;
            state <= dispatch_pkg::ST_DISPATCH;
          end
        end
        dispatch_pkg::ST_DISPATCH: state <= dispatch_pkg::ST_IDLE;
        dispatch_pkg::ST_RETURN: state <= dispatch_pkg::ST_IDLE;
        default: state <= dispatch_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // mode, pc load and enables
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      mode <= 1'b1;
      LIB_MODE_O <= 1'b1;
      INT_ENABLE_O <= 1'b0;
      IMAP_ENABLE_O <= 1'b0;
      PC_LOAD_O <= 1'b0;
      NEW_PC_O <= '0;
    end else if (CE_I) begin
      PC_LOAD_O <= 1'b0;
      if (state == dispatch_pkg::ST_DISPATCH) begin
        mode <= 1'b1;
        LIB_MODE_O <= 1'b1;
        INT_ENABLE_O <= 1'b0;
        IMAP_ENABLE_O <= 1'b0;
        PC_LOAD_O <= 1'b1;
        NEW_PC_O <= {base, sel_ofs};
      end else if (state == dispatch_pkg::ST_RETURN) begin
        mode <= era[dispatch_pkg::STAY_BIT];
        LIB_MODE_O <= era[dispatch_pkg::STAY_BIT];
        INT_ENABLE_O <= !era[dispatch_pkg::STAY_BIT];
        IMAP_ENABLE_O <= !era[dispatch_pkg::STAY_BIT];
        PC_LOAD_O <= 1'b1;
        NEW_PC_O <= {era[dispatch_pkg::PC_W-1:1], 1'b0};
      end
    end
  end

  // ==========================================================
  // wishbone slave: ack one cycle after the strobe
  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr = wb_req && WB_WE_I;
  assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

  // hardware save beats a same-cycle software write
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      base <= dispatch_pkg::BASE_RESET;
      era <= '0;
    end else if (CE_I) begin
      if (wb_wr && WB_ADR_I == dispatch_pkg::REG_BASE) begin
        base <= (base & ~wmask[19:0]) | (WB_DAT_I[19:0] & wmask[19:0]);
      end
      if (state == dispatch_pkg::ST_DISPATCH) begin
        case (sel_cause)
          dispatch_pkg::C_CALL: era <= call_ret;
          dispatch_pkg::C_ILLEGAL: era <= illegal_pc;
          default: era <= CUR_PC_I;
        endcase
      end else if (wb_wr && WB_ADR_I == dispatch_pkg::REG_ERA_LO) begin
        era[31:0] <= (era[31:0] & ~wmask) | (WB_DAT_I & wmask);
      end else if (wb_wr && WB_ADR_I == dispatch_pkg::REG_ERA_HI && WB_SEL_I[0]) begin
        era[33:32] <= WB_DAT_I[1:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else if (CE_I) begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= 32'h0000_0000;
      if (wb_req && !WB_WE_I) begin
        case (WB_ADR_I)
          dispatch_pkg::REG_BASE: WB_DAT_O <= {12'h000, base};
          dispatch_pkg::REG_ERA_LO: WB_DAT_O <= era[31:0];
          dispatch_pkg::REG_ERA_HI: WB_DAT_O <= {30'h0000_0000, era[33:32]};
          dispatch_pkg::REG_STATUS: WB_DAT_O <= {11'h000, 4'(sel_cause), state,
                                                 pend_reset, pend_machine_check_entry, pend_arithmetic_trap_entry, pend_intr,
                                                 pend_derr, pend_itb, pend_dtb, pend_ill,
                                                 pend_call, 3'h0, mode};
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I || !CE_I);

  a_drain_before_load: assert property (PC_LOAD_O && $past(state) == dispatch_pkg::ST_DISPATCH
      |-> $past(DRAIN_DONE_I, 2) && $past(DRAIN_REQ_O, 2))
    else $error("dispatch without drain");
  a_pc_from_base: assert property ((state == dispatch_pkg::ST_DISPATCH)
      |=> PC_LOAD_O && NEW_PC_O == {$past(base), $past(sel_ofs)})
    else $error("dispatch pc not base plus offset");
  a_mode_masks: assert property (LIB_MODE_O |-> !INT_ENABLE_O && !IMAP_ENABLE_O)
    else $error("enables on in library mode");
  a_native_trap: assert property (!mode && ISSUE_MODE_ONLY_I |=> pend_ill)
    else $error("mode-only instruction not trapped");
  a_return_exit: assert property ((state == dispatch_pkg::ST_RETURN) && !era[0]
      |=> !LIB_MODE_O && INT_ENABLE_O && IMAP_ENABLE_O && PC_LOAD_O)
    else $error("return did not leave mode");
  a_call_save: assert property ((state == dispatch_pkg::ST_DISPATCH)
      && sel_cause == dispatch_pkg::C_CALL |=> era == $past(call_ret))
    else $error("call saved wrong address");
  a_call_priv: assert property (ISSUE_CALL_I && !CALL_FUNC_I[7] && CUR_MODE_I != 2'h0
      |=> pend_ill)
    else $error("privileged call outside kernel not trapped");
  a_machine_check_entry_entry: assert property (take && next_cause == dispatch_pkg::C_MACHINE_CHECK_ENTRY
      |=> sel_ofs == dispatch_pkg::OFS_MACHINE_CHECK_ENTRY)
    else $error("machine check entry wrong");
  a_wait_in_mode: assert property ((state == dispatch_pkg::ST_IDLE) && mode && !pend_reset
      |-> !take)
    else $error("cause taken inside mode");
  a_ack_one: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");

  c_call_dispatch: cover property (take && next_cause == dispatch_pkg::C_CALL);
  c_return_native: cover property ((state == dispatch_pkg::ST_RETURN) && !era[0]);
  c_intr_dispatch: cover property (take && next_cause == dispatch_pkg::C_INTR);
  c_two_pending: cover property (take && pend_machine_check_entry && pend_intr);
endmodule : privileged_mode_dispatch

// File: tb/pipeline_model.sv
`timescale 1ns/1ps
module pipeline_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // drain handshake
  input wire logic drain_req_i,
  input wire logic [3:0] delay_i,
  output logic drain_done_o
);
  // ==========================================================
  // drain timing
  logic [3:0] cnt;
  // done is a one-cycle pulse and low when no drain is asked: no stale level
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !drain_req_i || drain_done_o) begin
      cnt <= 4'h0;
      drain_done_o <= 1'b0;
    end else if (cnt == delay_i) begin
      drain_done_o <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : pipeline_model

// File: tb/privileged_mode_dispatch_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module privileged_mode_dispatch_tb;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF, bsel = 4'hF;
  logic [31:0] wd = 32'h0000_0000, rd, q;
  logic [8:0] ev = 9'h000;
  logic [1:0] dty = 2'h0, md = 2'h0;
  logic [7:0] fn = 8'h00;
  logic [33:0] ipc = 34'h0_0000_4000, cpc = 34'h0_0000_1230, npc;
  logic [3:0] lat = 4'h1;
  logic [19:0] bas = 20'h0_0003;
  logic ack, drq, ddone, pld, lm, ie, me;
  int err_total = 0, comparisons = 0, cycles = 0;
  // event order: machine_check_entry arithmetic_trap_entry intr derr x4 itb dtb
  logic [8:0] evs [9] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h008, 9'h008, 9'h008,
    9'h010, 9'h020};
  logic [13:0] ofs [9] = '{dispatch_pkg::OFS_MACHINE_CHECK_ENTRY, dispatch_pkg::OFS_ARITHMETIC_TRAP_ENTRY,
    dispatch_pkg::OFS_INTR, dispatch_pkg::OFS_DERR0, dispatch_pkg::OFS_DERR1,
    dispatch_pkg::OFS_DERR2, dispatch_pkg::OFS_DERR3, dispatch_pkg::OFS_ITB,
    dispatch_pkg::OFS_DTB};
  // calls: kernel priv, top slot, user nonpriv, user priv, unsupported
  logic [7:0] cfn [5] = '{8'h05, 8'hBF, 8'h80, 8'h00, 8'h40};
  logic [1:0] cmd [5] = '{2'h0, 2'h0, 2'h3, 2'h3, 2'h0};
  logic [13:0] cof [5] = '{14'h2140, 14'h3FC0, 14'h3000, 14'h13E0, 14'h13E0};
  logic [31:0] cra [5] = '{32'h0000_4004, 32'h0000_4004, 32'h0000_4004,
    32'h0000_4000, 32'h0000_4000};
  always #25 clk = ~clk;
  // ==========================================================
  // device and pipeline
  privileged_mode_dispatch dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(1'b1),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack), .EVT_MACHINE_CHECK_ENTRY_I(ev[0]),
    .EVT_ARITHMETIC_TRAP_ENTRY_I(ev[1]), .EVT_INTR_I(ev[2]), .EVT_DERR_I(ev[3]), .DERR_TYPE_I(dty),
    .EVT_ITB_MISS_I(ev[4]), .EVT_DTB_MISS_I(ev[5]), .ISSUE_CALL_I(ev[6]),
    .CALL_FUNC_I(fn), .ISSUE_MODE_ONLY_I(ev[7]), .ISSUE_RETURN_I(ev[8]),
    .ISSUE_PC_I(ipc), .CUR_MODE_I(md), .CUR_PC_I(cpc), .DRAIN_REQ_O(drq),
    .DRAIN_DONE_I(ddone), .PC_LOAD_O(pld), .NEW_PC_O(npc), .LIB_MODE_O(lm),
    .INT_ENABLE_O(ie), .IMAP_ENABLE_O(me));
  pipeline_model pipe (.clk_i(clk), .rst_n_i(rst_n), .drain_req_i(drq),
    .delay_i(lat), .drain_done_o(ddone));
  // ==========================================================
  // tasks
  task automatic finish_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d; sel <= bsel;
    // ack and read data are taken at the very edge that samples ack high
    do begin n++; @(posedge clk); end while (ack !== 1'b1 && n < 20);
    r = rd;
    `CHK("bus ack", 1'b1, ack)
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb
  task automatic fire(input logic [8:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 9'h000;
  endtask : fire
  // waits for the pc load pulse, then checks target, mode and drain history
  task automatic wait_load(input logic [33:0] pc, input logic m, input logic dr);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    @(negedge clk);
    while (pld !== 1'b1 && n < 60) begin seen |= (drq === 1'b1); n++; @(negedge clk); end
    `CHK("new pc", pc, npc)
    `CHK("lib mode", m, lm)
    `CHK("int enable", ~m, ie)
    `CHK("map enable", ~m, me)
    `CHK("drained", dr, seen)
  endtask : wait_load
  task automatic leave(input logic [33:0] pc);
    fire(9'h100);
    wait_load(pc, 1'b0, 1'b0);
  endtask : leave
  // ==========================================================
  // hang guard: whole run is well under this
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      finish_test;
    end
  end
  // ==========================================================
  // sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    `CHK("reset mode", 1'b1, lm)
    `CHK("reset int", 1'b0, ie)
    `CHK("reset map", 1'b0, me)
    wait_load(34'h0_0000_0000, 1'b1, 1'b1);
    wb(1'b0, dispatch_pkg::REG_BASE, 32'h0000_0000, q);
    `CHK("base reset", 32'h0000_0000, q)
    wb(1'b0, dispatch_pkg::REG_STATUS, 32'h0000_0000, q);
    `CHK("status", 32'h0002_2001, q)
    bsel = 4'h2;
    wb(1'b1, dispatch_pkg::REG_BASE, 32'h0000_5503, q);
    bsel = 4'hF;
    wb(1'b0, dispatch_pkg::REG_BASE, 32'h0000_0000, q);
    `CHK("base lane", 32'h0000_5500, q)
    wb(1'b1, dispatch_pkg::REG_BASE, 32'h0000_0003, q);
    wb(1'b0, dispatch_pkg::REG_BASE, 32'h0000_0000, q);
    `CHK("base", 32'h0000_0003, q)
    wb(1'b0, 8'h40, 32'h0000_0000, q);
    `CHK("unmapped", 32'h0000_0000, q)
    wb(1'b1, dispatch_pkg::REG_ERA_HI, 32'h0000_0000, q);
    wb(1'b1, dispatch_pkg::REG_ERA_LO, 32'h0000_1231, q);
    fire(9'h100);
    wait_load(34'h0_0000_1230, 1'b1, 1'b0);
    wb(1'b1, dispatch_pkg::REG_ERA_LO, 32'h0000_1230, q);
    leave(34'h0_0000_1230);
    // each hardware cause alone, with varied drain latency
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      dty <= 2'(i + 1);
      lat <= 4'(i);
      fire(evs[i]);
      wait_load({bas, ofs[i]}, 1'b1, 1'b1);
      wb(1'b0, dispatch_pkg::REG_ERA_LO, 32'h0000_0000, q);
      `CHK("saved pc", cpc[31:0], q)
      leave(cpc);
    end
    // three causes at once: taken one by one in priority order
    fire(9'h007);
    wait_load({bas, dispatch_pkg::OFS_MACHINE_CHECK_ENTRY}, 1'b1, 1'b1);
    leave(cpc);
    wait_load({bas, dispatch_pkg::OFS_ARITHMETIC_TRAP_ENTRY}, 1'b1, 1'b1);
    leave(cpc);
    wait_load({bas, dispatch_pkg::OFS_INTR}, 1'b1, 1'b1);
    leave(cpc);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      fn <= cfn[i];
      md <= cmd[i];
      fire(9'h040);
      wait_load({bas, cof[i]}, 1'b1, 1'b1);
      wb(1'b0, dispatch_pkg::REG_ERA_LO, 32'h0000_0000, q);
      `CHK("call return", cra[i], q)
      leave({2'b00, cra[i]});
    end
    // mode-only and return issued in native mode
    fire(9'h080);
    wait_load({bas, dispatch_pkg::OFS_ILLEGAL}, 1'b1, 1'b1);
    leave(ipc);
    fire(9'h100);
    wait_load({bas, dispatch_pkg::OFS_ILLEGAL}, 1'b1, 1'b1);
    leave(ipc);
    finish_test;
  end
endmodule : privileged_mode_dispatch_tb
